/* File: core/rail_seq_pkg.sv */
// Shared constants, field layouts and carrier types for the rail sequencer
package rail_seq_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned NUM_RAILS = 12;
  localparam int unsigned GPI_COUNT = 8;
  localparam int unsigned GPI_SEL_W = 3;
  localparam int unsigned DELAY_W = 12;
  localparam int unsigned TON_MAX_W = 16;
  localparam int unsigned RAIL_IDX_W = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_PERIOD_MS = 1;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_MAX_MS = 3276;

  // ----------------------------------------
  // Per-rail fault status byte
  // ----------------------------------------
  localparam int unsigned RF_OV = 0;
  localparam int unsigned RF_UV = 1;
  localparam int unsigned RF_TON_MAX = 2;
  localparam int unsigned RF_OC = 3;
  localparam int unsigned RF_UC = 4;
  localparam int unsigned RF_OT = 5;
  localparam int unsigned RF_SEQ_WAIT = 6;
  localparam int unsigned RF_SLAVED = 7;
  localparam logic [7:0] RAIL_FAULT_RESET = 8'h00;

  // ----------------------------------------
  // Common fault summary byte
  // ----------------------------------------
  localparam int unsigned CF_LOG_NOT_EMPTY = 0;
  localparam logic [7:0] COMMON_FAULT_RESET = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RAIL_OFF,
    RAIL_ON_WAIT,
    RAIL_RAMP,
    RAIL_ON,
    RAIL_OFF_WAIT
  } rail_state_t;

  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic uc;
    logic ot;
    logic ut;
  } rail_fault_t;

  typedef struct packed {
    logic on_by_operation;
    logic on_by_pin;
    logic on_by_parents;
    logic on_by_gpi;
    logic [NUM_RAILS-1:0] parent_mask;
    logic [GPI_SEL_W-1:0] on_gpi_sel;
    logic on_gpi_level;
    logic [DELAY_W-1:0] turn_on_delay;
    logic off_by_operation;
    logic off_by_pin;
    logic off_by_gpi;
    logic [GPI_SEL_W-1:0] off_gpi_sel;
    logic off_gpi_level;
    logic off_immediate;
    logic [DELAY_W-1:0] turn_off_delay;
    logic [TON_MAX_W-1:0] max_turn_on_limit;
    logic [NUM_RAILS-1:0] follow_mask;
    logic follow_cascade;
    logic drive_cascade;
  } rail_cfg_t;

endpackage : rail_seq_pkg

/* File: core/ms_tick_gen.sv */
// Free-running divider giving a one-cycle pulse every millisecond
module ms_tick_gen #(
  parameter int unsigned TICK_CYCLES = rail_seq_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  output logic tick
);

  logic [31:0] count;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else if (count >= 32'(TICK_CYCLES - 1)) begin
      count <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick <= 1'b0;
    end
  end

endmodule : ms_tick_gen

/* File: core/rail_sequencer_fault_status.sv */
// Twelve-rail power sequencer with turn-on limit, fault shutdown and fault status
module rail_sequencer_fault_status #(
  parameter int unsigned TICK_CYCLES = rail_seq_pkg::TICK_CYCLES,
  parameter int unsigned GPI_COUNT = rail_seq_pkg::GPI_COUNT
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic auto_enable,
  input wire logic operation_on,
  input wire logic sequence_control_pin,
  input wire logic [GPI_COUNT-1:0] gpi_pin,
  input wire logic cascade_fault_pin,
  input wire rail_seq_pkg::rail_cfg_t [rail_seq_pkg::NUM_RAILS-1:0] rail_cfg,
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0] pg_above_on,
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0] pg_below_off,
  input wire rail_seq_pkg::rail_fault_t [rail_seq_pkg::NUM_RAILS-1:0] rail_fault_in,
  input wire logic [rail_seq_pkg::NUM_RAILS-1:0] status_clear,
  input wire logic common_clear,
  output logic [rail_seq_pkg::NUM_RAILS-1:0] rail_enable,
  output logic [rail_seq_pkg::NUM_RAILS-1:0] rail_in_regulation,
  output logic [rail_seq_pkg::NUM_RAILS-1:0][7:0] rail_fault_status,
  output logic [rail_seq_pkg::NUM_RAILS-1:0][rail_seq_pkg::TON_MAX_W-1:0] turn_on_time,
  output logic [7:0] common_fault_summary,
  output logic cascade_fault_out,
  output logic log_valid,
  output logic [rail_seq_pkg::RAIL_IDX_W-1:0] log_rail,
  output logic [7:0] log_fault
);

  localparam int unsigned N = rail_seq_pkg::NUM_RAILS;
  localparam int unsigned TW = rail_seq_pkg::TON_MAX_W;
  localparam int unsigned SW = GPI_COUNT + 2;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic gpi_match(
    input logic [GPI_COUNT-1:0] vec,
    input logic [rail_seq_pkg::GPI_SEL_W-1:0] sel,
    input logic level
  );
    gpi_match = (vec[sel] == level);
  endfunction : gpi_match

  function automatic logic delay_done(
    input logic [TW-1:0] count,
    input logic [rail_seq_pkg::DELAY_W-1:0] delay
  );
    delay_done = (count >= TW'(delay));
  endfunction : delay_done

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] sync_stage1;
  logic [SW-1:0] sync_stage2;
  logic pin_s;
  logic cascade_s;
  logic [GPI_COUNT-1:0] gpi_s;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_stage1 <= '0;
      sync_stage2 <= '0;
    end else begin
      sync_stage1 <= {cascade_fault_pin, sequence_control_pin, gpi_pin};
      sync_stage2 <= sync_stage1;
    end
  end

  assign gpi_s = sync_stage2[GPI_COUNT-1:0];
  assign pin_s = sync_stage2[GPI_COUNT];
  assign cascade_s = sync_stage2[GPI_COUNT+1];

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic tick;

  ms_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(tick)
  );

  // ----------------------------------------
  // Shared per-rail vectors
  // ----------------------------------------
  logic [N-1:0] fault_evt;
  logic [N-1:0] shut_pend;
  logic [N-1:0][7:0] set_bits;

  // ----------------------------------------
  // Per-rail sequencer
  // ----------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_rail
    rail_seq_pkg::rail_cfg_t cfg;
    rail_seq_pkg::rail_state_t state;
    logic [TW-1:0] cnt;
    logic pg;
    logic lock;
    logic any_on_src;
    logic on_ok;
    logic off_cmd;
    logic hw_fault;
    logic ton_expire;
    logic slave_fault;
    logic shut_now;

    assign cfg = rail_cfg[i];

    // Power-good hysteresis
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        pg <= 1'b0;
      end else if (pg_above_on[i]) begin
        pg <= 1'b1;
      end else if (pg_below_off[i]) begin
        pg <= 1'b0;
      end
    end

    // Trigger evaluation; selected turn-on triggers combine as an AND, turn-off triggers as an OR
    always_comb begin
      any_on_src = cfg.on_by_operation | cfg.on_by_pin | cfg.on_by_parents | cfg.on_by_gpi;
      on_ok = any_on_src;
      if (cfg.on_by_operation && !auto_enable) begin
        on_ok = on_ok & operation_on;
      end
      if (cfg.on_by_pin && !auto_enable) begin
        on_ok = on_ok & pin_s;
      end
      if (cfg.on_by_parents) begin
        on_ok = on_ok & (&(rail_in_regulation | ~cfg.parent_mask));
      end
      if (cfg.on_by_gpi) begin
        on_ok = on_ok & gpi_match(gpi_s, cfg.on_gpi_sel, cfg.on_gpi_level);
      end
      // Auto enable with only command or pin chosen still starts at power-up
      if (auto_enable && !cfg.on_by_parents && !cfg.on_by_gpi) begin
        on_ok = any_on_src;
      end
      off_cmd = 1'b0;
      if (cfg.off_by_operation && !auto_enable && !operation_on) begin
        off_cmd = 1'b1;
      end
      if (cfg.off_by_pin && !auto_enable && !pin_s) begin
        off_cmd = 1'b1;
      end
      if (cfg.off_by_gpi && gpi_match(gpi_s, cfg.off_gpi_sel, cfg.off_gpi_level)) begin
        off_cmd = 1'b1;
      end
    end

    // Fault detection
    assign hw_fault = |rail_fault_in[i];
    assign ton_expire = (state == rail_seq_pkg::RAIL_RAMP) && (cfg.max_turn_on_limit != '0)
      && (cnt >= cfg.max_turn_on_limit);
    assign fault_evt[i] = hw_fault | ton_expire;
    assign slave_fault = (|(fault_evt & cfg.follow_mask)) | (cfg.follow_cascade & cascade_s);
    assign shut_now = shut_pend[i] | ((state != rail_seq_pkg::RAIL_OFF) & (fault_evt[i] | slave_fault));

    // Pending fault shutdown, held until the rail is off
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        shut_pend[i] <= 1'b0;
      end else if (state == rail_seq_pkg::RAIL_OFF) begin
        shut_pend[i] <= 1'b0;
      end else if (fault_evt[i] || slave_fault) begin
        shut_pend[i] <= 1'b1;
      end
    end

    // A faulted rail stays off until its turn-on trigger is withdrawn
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        lock <= 1'b0;
      end else if (shut_now) begin
        lock <= 1'b1;
      end else if (!on_ok) begin
        lock <= 1'b0;
      end
    end

    // Sequencing state and the shared millisecond counter
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        state <= rail_seq_pkg::RAIL_OFF;
        cnt <= '0;
      end else begin
        case (state)
          rail_seq_pkg::RAIL_OFF: begin
            cnt <= '0;
            if (on_ok && !lock) begin
              state <= rail_seq_pkg::RAIL_ON_WAIT;
            end
          end
          rail_seq_pkg::RAIL_ON_WAIT: begin
            if (!on_ok || shut_now) begin
              state <= rail_seq_pkg::RAIL_OFF;
              cnt <= '0;
            end else if (delay_done(cnt, cfg.turn_on_delay)) begin
              state <= rail_seq_pkg::RAIL_RAMP;
              cnt <= '0;
            end else if (tick) begin
              cnt <= cnt + TW'(1);
            end
          end
          rail_seq_pkg::RAIL_RAMP, rail_seq_pkg::RAIL_ON: begin
            if (shut_now || off_cmd) begin
              cnt <= '0;
              if (cfg.off_immediate) begin
                state <= rail_seq_pkg::RAIL_OFF;
              end else begin
                state <= rail_seq_pkg::RAIL_OFF_WAIT;
              end
            end else if (state == rail_seq_pkg::RAIL_RAMP && pg) begin
              state <= rail_seq_pkg::RAIL_ON;
              cnt <= '0;
            end else if (state == rail_seq_pkg::RAIL_RAMP && tick && cnt != '1) begin
              cnt <= cnt + TW'(1);
            end
          end
          rail_seq_pkg::RAIL_OFF_WAIT: begin
            if (!shut_now && !off_cmd) begin
              // Soft-off trigger withdrawn before the delay ran out
              state <= pg ? rail_seq_pkg::RAIL_ON : rail_seq_pkg::RAIL_RAMP;
              cnt <= '0;
            end else if (delay_done(cnt, cfg.turn_off_delay)) begin
              state <= rail_seq_pkg::RAIL_OFF;
              cnt <= '0;
            end else if (tick) begin
              cnt <= cnt + TW'(1);
            end
          end
          default: begin
            state <= rail_seq_pkg::RAIL_OFF;
            cnt <= '0;
          end
        endcase
      end
    end

    // Enable output and regulation flag
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        rail_enable[i] <= 1'b0;
        rail_in_regulation[i] <= 1'b0;
      end else begin
        rail_enable[i] <= (state == rail_seq_pkg::RAIL_RAMP) || (state == rail_seq_pkg::RAIL_ON)
          || (state == rail_seq_pkg::RAIL_OFF_WAIT);
        rail_in_regulation[i] <= pg;
      end
    end

    // Last measured enable-to-power-good time
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        turn_on_time[i] <= '0;
      end else if (state == rail_seq_pkg::RAIL_RAMP && pg) begin
        turn_on_time[i] <= cnt;
      end
    end

    // Fault bits this cycle
    always_comb begin
      set_bits[i] = 8'h00;
      set_bits[i][rail_seq_pkg::RF_OV] = rail_fault_in[i].ov;
      set_bits[i][rail_seq_pkg::RF_UV] = rail_fault_in[i].uv;
      set_bits[i][rail_seq_pkg::RF_TON_MAX] = ton_expire;
      set_bits[i][rail_seq_pkg::RF_OC] = rail_fault_in[i].oc;
      set_bits[i][rail_seq_pkg::RF_UC] = rail_fault_in[i].uc;
      // No separate bit exists for undertemperature, so it shares the temperature bit
      set_bits[i][rail_seq_pkg::RF_OT] = rail_fault_in[i].ot | rail_fault_in[i].ut;
      set_bits[i][rail_seq_pkg::RF_SLAVED] = slave_fault && (state != rail_seq_pkg::RAIL_OFF);
    end

    // Sticky status byte; a new fault wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        rail_fault_status[i] <= rail_seq_pkg::RAIL_FAULT_RESET;
      end else if (status_clear[i]) begin
        rail_fault_status[i] <= set_bits[i];
      end else begin
        rail_fault_status[i] <= rail_fault_status[i] | set_bits[i];
      end
    end
  end : g_rail

  // ----------------------------------------
  // Cascade output to other controllers
  // ----------------------------------------
  logic [N-1:0] cascade_mask;

  always_comb begin
    for (int k = 0; k < N; k++) begin
      cascade_mask[k] = rail_cfg[k].drive_cascade;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cascade_fault_out <= 1'b0;
    end else begin
      cascade_fault_out <= |((shut_pend | fault_evt) & cascade_mask);
    end
  end

  // ----------------------------------------
  // Fault log offer
  // ----------------------------------------
  // One record per cycle; simultaneous faults on several rails log the lowest rail only
  logic [rail_seq_pkg::RAIL_IDX_W-1:0] first_rail;

  always_comb begin
    first_rail = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (set_bits[k] != 8'h00) begin
        first_rail = rail_seq_pkg::RAIL_IDX_W'(k);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      log_valid <= 1'b0;
      log_rail <= '0;
      log_fault <= 8'h00;
    end else begin
      log_valid <= |set_bits;
      log_rail <= first_rail;
      log_fault <= set_bits[first_rail];
    end
  end

  // ----------------------------------------
  // Common fault summary
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      common_fault_summary <= rail_seq_pkg::COMMON_FAULT_RESET;
    end else if (log_valid) begin
      common_fault_summary[rail_seq_pkg::CF_LOG_NOT_EMPTY] <= 1'b1;
    end else if (common_clear) begin
      common_fault_summary <= rail_seq_pkg::COMMON_FAULT_RESET;
    end
  end

endmodule : rail_sequencer_fault_status

/* File: testbench/rail_seq_asserts.sv */
// Port-level checks for the rail sequencer
module rail_seq_asserts #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned GPI_COUNT = 8,
  parameter int unsigned N = rail_seq_pkg::NUM_RAILS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic auto_enable,
  input wire logic operation_on,
  input wire logic sequence_control_pin,
  input wire logic [GPI_COUNT-1:0] gpi_pin,
  input wire logic cascade_fault_pin,
  input wire rail_seq_pkg::rail_cfg_t [N-1:0] rail_cfg,
  input wire logic [N-1:0] pg_above_on,
  input wire logic [N-1:0] pg_below_off,
  input wire rail_seq_pkg::rail_fault_t [N-1:0] rail_fault_in,
  input wire logic [N-1:0] status_clear,
  input wire logic common_clear,
  input wire logic [N-1:0] rail_enable,
  input wire logic [N-1:0] rail_in_regulation,
  input wire logic [N-1:0][7:0] rail_fault_status,
  input wire logic [N-1:0][rail_seq_pkg::TON_MAX_W-1:0] turn_on_time,
  input wire logic [7:0] common_fault_summary,
  input wire logic cascade_fault_out,
  input wire logic log_valid,
  input wire logic [rail_seq_pkg::RAIL_IDX_W-1:0] log_rail,
  input wire logic [7:0] log_fault
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Whole-block checks
  // ----------------------------------------
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |-> rail_enable == '0 && common_fault_summary == 8'h00)
    else $error("outputs active during reset");
  a_common_spare: assert property (common_fault_summary[7:1] == 7'h00)
    else $error("unused summary bits set");
  a_log_fields: assert property (log_valid |-> log_fault != 8'h00 && log_rail < 4'hC)
    else $error("bad log entry");
  a_log_marks: assert property (log_valid |=> common_fault_summary[0])
    else $error("log entry not marked in summary");
  c_logged: cover property (log_valid);
  c_cascade: cover property (cascade_fault_out);
  c_rail_up: cover property ($rose(rail_enable[0]));
  // ----------------------------------------
  // Per-rail checks
  // ----------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_rail
    a_status_sticky: assert property (!status_clear[i] |=> (rail_fault_status[i] & $past(rail_fault_status[i])) == $past(rail_fault_status[i]))
      else $error("status bit dropped without clear");
    a_reg_on: assert property (pg_above_on[i] |-> ##2 rail_in_regulation[i])
      else $error("regulation flag missed power-good-on");
    a_reg_off: assert property (!pg_above_on[i] && pg_below_off[i] |-> ##2 !rail_in_regulation[i])
      else $error("regulation flag kept below power-good-off");
    a_reg_hold: assert property (!pg_above_on[i] && !pg_below_off[i] |-> ##2 rail_in_regulation[i] == $past(rail_in_regulation[i]))
      else $error("regulation flag moved inside hysteresis");
    a_cut_immediate: assert property ($fell(operation_on) && rail_enable[i] && !auto_enable && rail_cfg[i].off_by_operation && rail_cfg[i].off_immediate |-> ##2 !rail_enable[i])
      else $error("immediate turn-off late");
  end
endmodule : rail_seq_asserts

bind rail_sequencer_fault_status rail_seq_asserts #(.TICK_CYCLES(TICK_CYCLES), .GPI_COUNT(GPI_COUNT)) u_chk (
  .core_clk, .resetn, .auto_enable, .operation_on, .sequence_control_pin, .gpi_pin, .cascade_fault_pin,
  .rail_cfg, .pg_above_on, .pg_below_off, .rail_fault_in, .status_clear, .common_clear, .rail_enable,
  .rail_in_regulation, .rail_fault_status, .turn_on_time, .common_fault_summary, .cascade_fault_out,
  .log_valid, .log_rail, .log_fault
);

/* File: testbench/rail_far_side.sv */
// Supplies behind the enables: ramp to power good, or never (stuck rails)
module rail_far_side #(
  parameter int RAMP_CYC = 5,
  parameter logic [11:0] STUCK_MASK = 12'h004
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [11:0] rail_enable,
  output logic [11:0] pg_above_on,
  output logic [11:0] pg_below_off
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt [12];
  // A stuck supply never reaches its power-good level, so the turn-on limit can fire
  always_ff @(posedge core_clk or negedge resetn) begin
    for (int i = 0; i < 12; i++) begin
      if (!resetn || !rail_enable[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] < RAMP_CYC) begin
        cnt[i] <= cnt[i] + 1;
      end
      pg_above_on[i] <= resetn && rail_enable[i] && cnt[i] == RAMP_CYC && !STUCK_MASK[i];
      pg_below_off[i] <= !rail_enable[i];
    end
  end
endmodule : rail_far_side

/* File: testbench/rail_sequencer_fault_status_tb.sv */
// Self-checking bench for the rail sequencer
module rail_sequencer_fault_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TICK = 10;
  logic core_clk = 1'b0;
  logic resetn = 1'b1;
  logic auto_enable = 1'b0;
  logic operation_on = 1'b0;
  logic sequence_control_pin = 1'b0;
  logic [7:0] gpi_pin = 8'h00;
  rail_seq_pkg::rail_cfg_t [11:0] rail_cfg = '0;
  rail_seq_pkg::rail_fault_t [11:0] rail_fault_in = '0;
  logic [11:0] status_clear = 12'h000;
  logic common_clear = 1'b0;
  logic cascade_fault_pin = 1'b0;
  logic [11:0] pg_above_on, pg_below_off, rail_enable, rail_in_regulation;
  logic [11:0][7:0] rail_fault_status;
  logic [11:0][15:0] turn_on_time;
  logic [7:0] common_fault_summary, log_fault;
  logic [3:0] log_rail, last_log_rail;
  logic cascade_fault_out, log_valid;
  logic seen_cascade = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  rail_sequencer_fault_status #(.TICK_CYCLES(TICK), .GPI_COUNT(8)) DUT (
    .core_clk(core_clk), .resetn(resetn), .auto_enable(auto_enable), .operation_on(operation_on),
    .sequence_control_pin(sequence_control_pin), .gpi_pin(gpi_pin), .cascade_fault_pin(cascade_fault_pin),
    .rail_cfg(rail_cfg), .pg_above_on(pg_above_on), .pg_below_off(pg_below_off),
    .rail_fault_in(rail_fault_in), .status_clear(status_clear), .common_clear(common_clear),
    .rail_enable(rail_enable), .rail_in_regulation(rail_in_regulation), .rail_fault_status(rail_fault_status),
    .turn_on_time(turn_on_time), .common_fault_summary(common_fault_summary), .cascade_fault_out(cascade_fault_out),
    .log_valid(log_valid), .log_rail(log_rail), .log_fault(log_fault));
  rail_far_side #(.RAMP_CYC(5), .STUCK_MASK(12'h004)) far (.core_clk(core_clk), .resetn(resetn),
    .rail_enable(rail_enable), .pg_above_on(pg_above_on), .pg_below_off(pg_below_off));
  always @(posedge core_clk) begin
    if (log_valid === 1'b1) last_log_rail <= log_rail;
    if (cascade_fault_out === 1'b1) seen_cascade <= 1'b1;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded so a dead rail cannot hang the run
  task wait_en(input int idx, input logic lvl, output int n);
    n = 0;
    while (rail_enable[idx] !== lvl && n < 600) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(rail_enable[idx], lvl);
  endtask : wait_en
  task wait_stat(input int idx, input int b, output int n);
    n = 0;
    while (rail_fault_status[idx][b] !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(rail_fault_status[idx][b], 1'b1);
  endtask : wait_stat
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_operation;
    int n;
    @(posedge core_clk);
    operation_on <= 1'b1;
    wait_en(0, 1'b1, n);
    chk(n > TICK && n <= 3 * TICK + 4, 1'b1);
    wait_en(1, 1'b1, n);
    chk(rail_in_regulation[0], 1'b1);
    // Model ramps well inside one tick, so no whole millisecond is counted
    chk(turn_on_time[0], 16'h0000);
    repeat (20) @(posedge core_clk);
    operation_on <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(rail_enable[0], 1'b1);
    @(posedge core_clk);
    #1;
    chk(rail_enable[0], 1'b0);
    chk(rail_enable[1], 1'b1);
    wait_en(1, 1'b0, n);
    chk(n > TICK, 1'b1);
    $display("test operation done");
  endtask : t_operation
  task t_pin_limit;
    int n;
    @(posedge core_clk);
    sequence_control_pin <= 1'b1;
    wait_en(2, 1'b1, n);
    wait_stat(2, rail_seq_pkg::RF_TON_MAX, n);
    chk(n > 2 * TICK && n <= 3 * TICK + 4, 1'b1);
    wait_en(2, 1'b0, n);
    chk(last_log_rail, 4'h2);
    chk(common_fault_summary[0], 1'b1);
    @(posedge core_clk);
    status_clear <= 12'h004;
    @(posedge core_clk);
    status_clear <= 12'h000;
    common_clear <= 1'b1;
    @(posedge core_clk);
    common_clear <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(rail_fault_status[2], 8'h00);
    chk(common_fault_summary, 8'h00);
    @(posedge core_clk);
    sequence_control_pin <= 1'b0;
    $display("test pin limit done");
  endtask : t_pin_limit
  task t_gpi;
    int n;
    @(posedge core_clk);
    gpi_pin[2] <= 1'b1;
    wait_en(3, 1'b1, n);
    @(posedge core_clk);
    cascade_fault_pin <= 1'b1;
    wait_stat(3, rail_seq_pkg::RF_SLAVED, n);
    wait_en(3, 1'b0, n);
    @(posedge core_clk);
    cascade_fault_pin <= 1'b0;
    gpi_pin[2] <= 1'b0;
    repeat (4) @(posedge core_clk);
    gpi_pin[2] <= 1'b1;
    wait_en(3, 1'b1, n);
    @(posedge core_clk);
    gpi_pin[2] <= 1'b0;
    wait_en(3, 1'b0, n);
    $display("test input state done");
  endtask : t_gpi
  task t_fault;
    int n;
    @(posedge core_clk);
    operation_on <= 1'b1;
    wait_en(1, 1'b1, n);
    @(posedge core_clk);
    rail_fault_in[0].ov <= 1'b1;
    wait_stat(0, rail_seq_pkg::RF_OV, n);
    wait_en(0, 1'b0, n);
    repeat (3) @(posedge core_clk);
    #1;
    chk(rail_enable[1], 1'b1);
    wait_stat(1, rail_seq_pkg::RF_SLAVED, n);
    wait_en(1, 1'b0, n);
    chk(seen_cascade, 1'b1);
    @(posedge core_clk);
    rail_fault_in[0].ov <= 1'b0;
    operation_on <= 1'b0;
    $display("test fault shutdown done");
  endtask : t_fault
  task t_auto;
    int n;
    @(posedge core_clk);
    resetn <= 1'b0;
    auto_enable <= 1'b1;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk(rail_fault_status[0], 8'h00);
    wait_en(0, 1'b1, n);
    $display("test auto enable done");
  endtask : t_auto
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    // Falling edge after all processes wait, so every flop resets before the first clock
    resetn <= 1'b0;
    rail_cfg[0].on_by_operation = 1'b1;
    rail_cfg[0].turn_on_delay = 12'h002;
    rail_cfg[0].off_by_operation = 1'b1;
    rail_cfg[0].off_immediate = 1'b1;
    rail_cfg[0].drive_cascade = 1'b1;
    rail_cfg[1].on_by_parents = 1'b1;
    rail_cfg[1].parent_mask = 12'h001;
    rail_cfg[1].turn_on_delay = 12'h001;
    rail_cfg[1].off_by_operation = 1'b1;
    rail_cfg[1].turn_off_delay = 12'h003;
    rail_cfg[1].follow_mask = 12'h001;
    rail_cfg[2].on_by_pin = 1'b1;
    rail_cfg[2].off_by_pin = 1'b1;
    rail_cfg[2].off_immediate = 1'b1;
    rail_cfg[2].max_turn_on_limit = 16'h0003;
    rail_cfg[3].on_by_gpi = 1'b1;
    rail_cfg[3].on_gpi_sel = 3'h2;
    rail_cfg[3].on_gpi_level = 1'b1;
    rail_cfg[3].off_by_gpi = 1'b1;
    rail_cfg[3].off_gpi_sel = 3'h2;
    rail_cfg[3].off_immediate = 1'b1;
    rail_cfg[3].follow_cascade = 1'b1;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(rail_enable, 12'h000);
    t_operation();
    t_pin_limit();
    t_gpi();
    t_fault();
    t_auto();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule : rail_sequencer_fault_status_tb
